// File: pcdovr_port_override.sv
`timescale 1ns/1ps
`default_nettype none
module pcdovr_port_override (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       global_pullup_disable_i,
	input  wire logic       sleep_input_disable_i,
	input  wire logic [7:0] port_c_direction_i,
	input  wire logic [7:0] port_c_output_latch_i,
	input  wire logic [7:4] port_d_direction_i,
	input  wire logic [7:4] port_d_output_latch_i,
	input  wire logic [7:0] pad_c_in_i,
	input  wire logic [7:4] pad_d_in_i,
	input  wire logic       pad_d0_in_i,
	input  wire logic       timer2_async_select_i,
	input  wire logic       timer2_ext_clock_select_i,
	input  wire logic       jtag_port_enable_i,
	input  wire logic       tap_shift_instruction_state_i,
	input  wire logic       tap_shift_data_state_i,
	input  wire logic       jtag_tdo_i,
	input  wire logic       two_wire_enable_i,
	input  wire logic       two_wire_sda_out_i,
	input  wire logic       two_wire_scl_out_i,
	input  wire logic       port_c_pin_change_group_enable_i,
	input  wire logic       port_d_pin_change_group_enable_i,
	input  wire logic [7:0] port_c_pin_change_mask_i,
	input  wire logic [7:4] port_d_pin_change_mask_i,
	input  wire logic       port_d0_pin_change_mask_i,
	input  wire logic       timer2_compare_a_enable_i,
	input  wire logic       timer2_compare_a_out_i,
	input  wire logic       timer2_compare_b_enable_i,
	input  wire logic       timer2_compare_b_out_i,
	input  wire logic       timer1_compare_a_enable_i,
	input  wire logic       timer1_compare_a_out_i,
	input  wire logic       timer1_compare_b_enable_i,
	input  wire logic       timer1_compare_b_out_i,
	input  wire logic       usart1_sync_mode_i,
	input  wire logic       usart1_sync_clock_out_i,
	output logic      [7:0] pad_c_out_o,
	output logic      [7:0] pad_c_oe_n_o,
	output logic      [7:0] pad_c_pullup_o,
	output logic      [7:0] pad_c_input_enable_o,
	output logic      [7:4] pad_d_out_o,
	output logic      [7:4] pad_d_oe_n_o,
	output logic      [7:4] pad_d_pullup_o,
	output logic      [7:4] pad_d_input_enable_o,
	output logic      [7:0] pin_change_c_o,
	output logic      [7:4] pin_change_d_o,
	output logic            pin_change_24_o,
	output logic            jtag_tdi_o,
	output logic            jtag_tms_o,
	output logic            jtag_tck_o,
	output logic            two_wire_sda_in_o,
	output logic            two_wire_scl_in_o,
	output logic            timer2_osc_input_o,
	output logic            timer2_osc_output_active_o,
	output logic            timer1_capture_in_o,
	output logic            usart1_sync_clock_o,
	output logic            usart0_rx_o,
	output logic            timer3_count_input_o
);
	logic [7:0] c_pu_en, c_pu_val, c_dir_en, c_dir_val, c_out_en, c_out_val, c_ie_en, c_ie_val;
	logic [7:4] d_out_en, d_out_val, d_ie_en;
	logic [7:0] c_pull, c_dir, c_out, c_die;
	logic [7:4] d_pull, d_dir, d_out, d_die;
	logic [7:0] c_pc_req;
	logic [7:4] d_pc_req;
	logic       async_ext;
	logic       tap_shifting;
	logic       d0_die;
	logic       usart1_drive;

	assign async_ext    = timer2_async_select_i & timer2_ext_clock_select_i;
	assign tap_shifting = tap_shift_instruction_state_i | tap_shift_data_state_i;
	assign c_pc_req     = port_c_pin_change_mask_i & {8{port_c_pin_change_group_enable_i}};
	assign d_pc_req     = port_d_pin_change_mask_i & {4{port_d_pin_change_group_enable_i}};
	assign usart1_drive = usart1_sync_mode_i & port_d_direction_i[pcdovr_pkg::D_U1CLK_BIT];

	// Port C override terms. A pin-change request always asks for the input to stay on.
	always_comb begin
		c_pu_en   = '0;
		c_pu_val  = '0;
		c_dir_en  = '0;
		c_dir_val = '0;
		c_out_en  = '0;
		c_out_val = '0;
		c_ie_en   = c_pc_req;
		c_ie_val  = c_pc_req;
		c_pu_en[pcdovr_pkg::C_OSC_O_BIT]  = async_ext;
		c_dir_en[pcdovr_pkg::C_OSC_O_BIT] = async_ext;
		c_ie_en[pcdovr_pkg::C_OSC_O_BIT]  = async_ext | c_pc_req[pcdovr_pkg::C_OSC_O_BIT];
		c_ie_val[pcdovr_pkg::C_OSC_O_BIT] = timer2_async_select_i | c_pc_req[pcdovr_pkg::C_OSC_O_BIT];
		c_pu_en[pcdovr_pkg::C_OSC_I_BIT]  = timer2_async_select_i;
		c_dir_en[pcdovr_pkg::C_OSC_I_BIT] = timer2_async_select_i;
		c_ie_en[pcdovr_pkg::C_OSC_I_BIT]  = timer2_async_select_i | c_pc_req[pcdovr_pkg::C_OSC_I_BIT];
		c_ie_val[pcdovr_pkg::C_OSC_I_BIT] = timer2_ext_clock_select_i | timer2_async_select_i
		                                  | c_pc_req[pcdovr_pkg::C_OSC_I_BIT];
		for (int b = pcdovr_pkg::C_TCK_BIT; b <= pcdovr_pkg::C_TDI_BIT; b++) begin
			c_pu_en[b]  = jtag_port_enable_i;
			c_pu_val[b] = 1'b1;
			c_dir_en[b] = jtag_port_enable_i;
			c_ie_en[b]  = jtag_port_enable_i | c_pc_req[b];
			c_ie_val[b] = jtag_port_enable_i | c_pc_req[b];
		end
		c_dir_val[pcdovr_pkg::C_TDO_BIT] = tap_shifting;
		c_out_en[pcdovr_pkg::C_TDO_BIT]  = jtag_port_enable_i;
		c_out_val[pcdovr_pkg::C_TDO_BIT] = jtag_tdo_i;
		for (int b = pcdovr_pkg::C_SCL_BIT; b <= pcdovr_pkg::C_SDA_BIT; b++) begin
			c_pu_en[b]  = two_wire_enable_i;
			c_pu_val[b] = port_c_output_latch_i[b] & ~global_pullup_disable_i;
			c_dir_en[b] = two_wire_enable_i;
			c_out_en[b] = two_wire_enable_i;
		end
		c_out_val[pcdovr_pkg::C_SDA_BIT] = two_wire_sda_out_i;
		c_out_val[pcdovr_pkg::C_SCL_BIT] = two_wire_scl_out_i;
	end

	// Port D upper half: only output values and input enables are overridden.
	// Direction stays with software, so a compare output reaches the pad only when it sets the bit.
	always_comb begin
		d_ie_en = d_pc_req;
		d_out_en[pcdovr_pkg::D_T2CMPA_BIT]  = timer2_compare_a_enable_i;
		d_out_val[pcdovr_pkg::D_T2CMPA_BIT] = timer2_compare_a_out_i;
		d_out_en[pcdovr_pkg::D_T2CMPB_BIT]  = timer2_compare_b_enable_i;
		d_out_val[pcdovr_pkg::D_T2CMPB_BIT] = timer2_compare_b_out_i;
		d_out_en[pcdovr_pkg::D_T1CMPA_BIT]  = timer1_compare_a_enable_i;
		d_out_val[pcdovr_pkg::D_T1CMPA_BIT] = timer1_compare_a_out_i;
		// The compare output wins over the USART clock when both claim the pin.
		d_out_en[pcdovr_pkg::D_T1CMPB_BIT]  = timer1_compare_b_enable_i | usart1_drive;
		d_out_val[pcdovr_pkg::D_T1CMPB_BIT] = timer1_compare_b_enable_i ? timer1_compare_b_out_i
		                                                                : usart1_sync_clock_out_i;
	end

	pcdovr_pin_mux #(
		.WIDTH(pcdovr_pkg::C_WIDTH)
	) u_mux_c (
		.direction_i                    (port_c_direction_i),
		.output_latch_i                 (port_c_output_latch_i),
		.global_pullup_disable_i        (global_pullup_disable_i),
		.normal_input_enable_i          ({8{~sleep_input_disable_i}}),
		.pullup_override_enable_i       (c_pu_en),
		.pullup_override_value_i        (c_pu_val),
		.direction_override_enable_i    (c_dir_en),
		.direction_override_value_i     (c_dir_val),
		.output_value_override_enable_i (c_out_en),
		.output_value_override_value_i  (c_out_val),
		.input_enable_override_enable_i (c_ie_en),
		.input_enable_override_value_i  (c_ie_val),
		.pullup_o                       (c_pull),
		.direction_o                    (c_dir),
		.out_value_o                    (c_out),
		.input_enable_o                 (c_die)
	);

	pcdovr_pin_mux #(
		.WIDTH(pcdovr_pkg::D_WIDTH)
	) u_mux_d (
		.direction_i                    (port_d_direction_i),
		.output_latch_i                 (port_d_output_latch_i),
		.global_pullup_disable_i        (global_pullup_disable_i),
		.normal_input_enable_i          ({4{~sleep_input_disable_i}}),
		.pullup_override_enable_i       (4'h0),
		.pullup_override_value_i        (4'h0),
		.direction_override_enable_i    (4'h0),
		.direction_override_value_i     (4'h0),
		.output_value_override_enable_i (d_out_en),
		.output_value_override_value_i  (d_out_val),
		.input_enable_override_enable_i (d_ie_en),
		.input_enable_override_value_i  (4'hF),
		.pullup_o                       (d_pull),
		.direction_o                    (d_dir),
		.out_value_o                    (d_out),
		.input_enable_o                 (d_die)
	);

	assign d0_die = port_d0_pin_change_mask_i & port_d_pin_change_group_enable_i | ~sleep_input_disable_i;

	// Pad controls are registered so the pads see glitch-free levels at one cycle of latency.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pad_c_out_o          <= {8{pcdovr_pkg::RST_OUT}};
			pad_c_oe_n_o         <= {8{pcdovr_pkg::RST_OE_N}};
			pad_c_pullup_o       <= {8{pcdovr_pkg::RST_PULLUP}};
			pad_c_input_enable_o <= {8{pcdovr_pkg::RST_DIE}};
			pad_d_out_o          <= {4{pcdovr_pkg::RST_OUT}};
			pad_d_oe_n_o         <= {4{pcdovr_pkg::RST_OE_N}};
			pad_d_pullup_o       <= {4{pcdovr_pkg::RST_PULLUP}};
			pad_d_input_enable_o <= {4{pcdovr_pkg::RST_DIE}};
		end else begin
			pad_c_out_o          <= c_out;
			pad_c_oe_n_o         <= ~c_dir;
			pad_c_pullup_o       <= c_pull;
			pad_c_input_enable_o <= c_die;
			pad_d_out_o          <= d_out;
			pad_d_oe_n_o         <= ~d_dir;
			pad_d_pullup_o       <= d_pull;
			pad_d_input_enable_o <= d_die;
		end
	end

	// Digital pin-change sources see the pad only through the input enable.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_change_c_o  <= {8{pcdovr_pkg::RST_ROUTE}};
			pin_change_d_o  <= {4{pcdovr_pkg::RST_ROUTE}};
			pin_change_24_o <= pcdovr_pkg::RST_ROUTE;
		end else begin
			pin_change_c_o  <= pad_c_in_i & c_die;
			pin_change_d_o  <= pad_d_in_i & d_die;
			pin_change_24_o <= pad_d0_in_i & d0_die;
		end
	end

	// Peripheral inputs taken from the pads, and the oscillator output-active flag.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			jtag_tdi_o                 <= pcdovr_pkg::RST_ROUTE;
			jtag_tms_o                 <= pcdovr_pkg::RST_ROUTE;
			jtag_tck_o                 <= pcdovr_pkg::RST_ROUTE;
			two_wire_sda_in_o          <= pcdovr_pkg::RST_ROUTE;
			two_wire_scl_in_o          <= pcdovr_pkg::RST_ROUTE;
			timer2_osc_input_o         <= pcdovr_pkg::RST_ROUTE;
			timer2_osc_output_active_o <= pcdovr_pkg::RST_ROUTE;
			timer1_capture_in_o        <= pcdovr_pkg::RST_ROUTE;
			usart1_sync_clock_o        <= pcdovr_pkg::RST_ROUTE;
			usart0_rx_o                <= pcdovr_pkg::RST_ROUTE;
			timer3_count_input_o       <= pcdovr_pkg::RST_ROUTE;
		end else begin
			jtag_tdi_o                 <= jtag_port_enable_i & pad_c_in_i[pcdovr_pkg::C_TDI_BIT];
			jtag_tms_o                 <= jtag_port_enable_i & pad_c_in_i[pcdovr_pkg::C_TMS_BIT];
			jtag_tck_o                 <= jtag_port_enable_i & pad_c_in_i[pcdovr_pkg::C_TCK_BIT];
			two_wire_sda_in_o          <= pad_c_in_i[pcdovr_pkg::C_SDA_BIT];
			two_wire_scl_in_o          <= pad_c_in_i[pcdovr_pkg::C_SCL_BIT];
			timer2_osc_input_o         <= timer2_async_select_i & pad_c_in_i[pcdovr_pkg::C_OSC_I_BIT];
			timer2_osc_output_active_o <= async_ext;
			timer1_capture_in_o        <= pad_d_in_i[pcdovr_pkg::D_T1CAPT_BIT]
			                            & d_die[pcdovr_pkg::D_T1CAPT_BIT];
			usart1_sync_clock_o        <= usart1_sync_mode_i & ~port_d_direction_i[pcdovr_pkg::D_U1CLK_BIT]
			                            & pad_d_in_i[pcdovr_pkg::D_U1CLK_BIT];
			usart0_rx_o                <= pad_d0_in_i & d0_die;
			timer3_count_input_o       <= pad_d0_in_i & d0_die;
		end
	end

	sequence tap_shift_s;
		jtag_port_enable_i && tap_shifting;
	endsequence

	sequence tap_idle_s;
		jtag_port_enable_i && !tap_shifting;
	endsequence

	tdo_drive_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		tap_shift_s |=> (!pad_c_oe_n_o[pcdovr_pkg::C_TDO_BIT]
		                && pad_c_out_o[pcdovr_pkg::C_TDO_BIT] == $past(jtag_tdo_i)))
		else $error("TDO pad not driven while shifting");

	tdo_release_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		tap_idle_s |=> pad_c_oe_n_o[pcdovr_pkg::C_TDO_BIT] && pad_c_pullup_o[pcdovr_pkg::C_TDI_BIT])
		else $error("TDO pad driven outside shift");

	jtag_inputs_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		jtag_port_enable_i |=> (pad_c_pullup_o[3:2] == 2'h3 && pad_c_oe_n_o[3:2] == 2'h3
		                        && jtag_tms_o == $past(pad_c_in_i[pcdovr_pkg::C_TMS_BIT])))
		else $error("TMS or TCK pad not forced to pulled input");

	twi_drive_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		two_wire_enable_i |=> (pad_c_out_o[1] == $past(two_wire_sda_out_i)
		                       && pad_c_out_o[0] == $past(two_wire_scl_out_i)
		                       && pad_c_oe_n_o[1:0] == 2'h3))
		else $error("Two-wire pins not overridden");

	tosc_input_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		timer2_async_select_i |=> (!pad_c_pullup_o[pcdovr_pkg::C_OSC_I_BIT]
		                           && pad_c_oe_n_o[pcdovr_pkg::C_OSC_I_BIT]
		                           && pad_c_input_enable_o[pcdovr_pkg::C_OSC_I_BIT]))
		else $error("Oscillator input pin not released");

	tosc_output_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		async_ext |=> (!pad_c_pullup_o[pcdovr_pkg::C_OSC_O_BIT] && pad_c_oe_n_o[pcdovr_pkg::C_OSC_O_BIT]
		               && timer2_osc_output_active_o))
		else $error("Oscillator output pin not released");

	pc_enable_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		c_pc_req[pcdovr_pkg::C_SCL_BIT] |=> pad_c_input_enable_o[pcdovr_pkg::C_SCL_BIT]
		                                   && pin_change_c_o[0] == $past(pad_c_in_i[0]))
		else $error("Pin change source lost its input");

	cmp_out_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		timer1_compare_a_enable_i && port_d_direction_i[5]
		|=> !pad_d_oe_n_o[5] && pad_d_out_o[5] == $past(timer1_compare_a_out_i))
		else $error("Timer1 compare A not on pad");

	pullup_kill_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		global_pullup_disable_i |=> pad_d_pullup_o == 4'h0)
		else $error("Pull-up active under global disable");

	plain_port_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!timer1_compare_b_enable_i && !usart1_sync_mode_i
		|=> pad_d_out_o[4] == $past(port_d_output_latch_i[4]) && pad_d_oe_n_o[4] == !$past(port_d_direction_i[4]))
		else $error("Plain port value not used without override");

	d0_route_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		port_d0_pin_change_mask_i && port_d_pin_change_group_enable_i
		|=> usart0_rx_o == $past(pad_d0_in_i) && timer3_count_input_o == $past(pad_d0_in_i))
		else $error("Port D bit 0 input not routed");

	usart_clock_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		usart1_sync_mode_i && !timer1_compare_b_enable_i && port_d_direction_i[4]
		|=> !pad_d_oe_n_o[4] && pad_d_out_o[4] == $past(usart1_sync_clock_out_i))
		else $error("USART1 clock not on pad");
endmodule // pcdovr_port_override
`default_nettype wire

// File: pcdovr_pkg.sv
`default_nettype none
package pcdovr_pkg;
	// Port C bit positions of the alternate functions.
	localparam int unsigned C_SCL_BIT   = 0;
	localparam int unsigned C_SDA_BIT   = 1;
	localparam int unsigned C_TCK_BIT   = 2;
	localparam int unsigned C_TMS_BIT   = 3;
	localparam int unsigned C_TDO_BIT   = 4;
	localparam int unsigned C_TDI_BIT   = 5;
	localparam int unsigned C_OSC_I_BIT = 6;
	localparam int unsigned C_OSC_O_BIT = 7;
	// Port D upper-half bit positions.
	localparam int unsigned D_T1CMPB_BIT = 4;
	localparam int unsigned D_U1CLK_BIT  = 4;
	localparam int unsigned D_T1CMPA_BIT = 5;
	localparam int unsigned D_T1CAPT_BIT = 6;
	localparam int unsigned D_T2CMPB_BIT = 6;
	localparam int unsigned D_T2CMPA_BIT = 7;
	// Width of each port slice handled here.
	localparam int unsigned C_WIDTH     = 8;
	localparam int unsigned D_WIDTH     = 4;
	// Reset values of the registered pad and peripheral outputs.
	localparam logic RST_OE_N   = 1'b1;
	localparam logic RST_OUT    = 1'b0;
	localparam logic RST_PULLUP = 1'b0;
	localparam logic RST_DIE    = 1'b0;
	localparam logic RST_ROUTE  = 1'b0;
endpackage
`default_nettype wire

// File: pcdovr_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pcdovr_pin_mux #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] direction_i,
	input  wire logic [WIDTH-1:0] output_latch_i,
	input  wire logic             global_pullup_disable_i,
	input  wire logic [WIDTH-1:0] normal_input_enable_i,
	input  wire logic [WIDTH-1:0] pullup_override_enable_i,
	input  wire logic [WIDTH-1:0] pullup_override_value_i,
	input  wire logic [WIDTH-1:0] direction_override_enable_i,
	input  wire logic [WIDTH-1:0] direction_override_value_i,
	input  wire logic [WIDTH-1:0] output_value_override_enable_i,
	input  wire logic [WIDTH-1:0] output_value_override_value_i,
	input  wire logic [WIDTH-1:0] input_enable_override_enable_i,
	input  wire logic [WIDTH-1:0] input_enable_override_value_i,
	output logic      [WIDTH-1:0] pullup_o,
	output logic      [WIDTH-1:0] direction_o,
	output logic      [WIDTH-1:0] out_value_o,
	output logic      [WIDTH-1:0] input_enable_o
);
	logic [WIDTH-1:0] normal_pullup;

	// One override rule serves all four pin attributes, so it lives in one place.
	function automatic logic [WIDTH-1:0] select_override(input logic [WIDTH-1:0] en,
	                                                     input logic [WIDTH-1:0] val,
	                                                     input logic [WIDTH-1:0] plain);
		select_override = (en & val) | (~en & plain);
	endfunction

	// Input with latch high asks for the pull-up unless globally disabled.
	assign normal_pullup = ~direction_i & output_latch_i & {WIDTH{~global_pullup_disable_i}};

	// Each attribute falls back to the plain port unless its override enable is high.
	assign pullup_o       = select_override(pullup_override_enable_i, pullup_override_value_i,
	                                        normal_pullup);
	assign direction_o    = select_override(direction_override_enable_i, direction_override_value_i,
	                                        direction_i);
	assign out_value_o    = select_override(output_value_override_enable_i, output_value_override_value_i,
	                                        output_latch_i);
	assign input_enable_o = select_override(input_enable_override_enable_i, input_enable_override_value_i,
	                                        normal_input_enable_i);
endmodule // pcdovr_pin_mux
`default_nettype wire

// File: pcdovr_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcdovr_pad_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] c_out_i,
	input  wire logic [7:0] c_oe_n_i,
	input  wire logic [7:0] c_pu_i,
	input  wire logic [7:0] c_ext_en_i,
	input  wire logic [7:0] c_ext_i,
	input  wire logic [7:4] d_out_i,
	input  wire logic [7:4] d_oe_n_i,
	input  wire logic [7:4] d_pu_i,
	input  wire logic [7:4] d_ext_en_i,
	input  wire logic [7:4] d_ext_i,
	output logic      [7:0] c_pad_o,
	output logic      [7:4] d_pad_o
);
	// A released line with no pull-up and no external drive flips each cycle, so a stale level never passes for a driven one.
	logic [7:0] float_r = 8'h5A;
	always_ff @(posedge clk_i) begin
		float_r <= ~float_r;
	end
	assign c_pad_o = (~c_oe_n_i & c_out_i) | (c_oe_n_i & c_ext_en_i & c_ext_i)
		| (c_oe_n_i & ~c_ext_en_i & (c_pu_i | float_r));
	assign d_pad_o = (~d_oe_n_i & d_out_i) | (d_oe_n_i & d_ext_en_i & d_ext_i)
		| (d_oe_n_i & ~d_ext_en_i & (d_pu_i | float_r[7:4]));
endmodule // pcdovr_pad_model
`default_nettype wire

// File: tb_pcdovr_port_override.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcdovr_port_override;
	logic clk_i = '0, rst_n_i = '0, global_pullup_disable_i = '0, sleep_input_disable_i = '0;
	logic pad_d0_in_i = '0, timer2_async_select_i = '0, timer2_ext_clock_select_i = '0;
	logic jtag_port_enable_i = '0, jtag_tdo_i = '0, tap_shift_instruction_state_i = '0;
	logic tap_shift_data_state_i = '0, two_wire_enable_i = '0, two_wire_sda_out_i = '0;
	logic two_wire_scl_out_i = '0, port_c_pin_change_group_enable_i = '0, usart1_sync_mode_i = '0;
	logic port_d_pin_change_group_enable_i = '0, port_d0_pin_change_mask_i = '0;
	logic timer2_compare_a_enable_i = '0, timer2_compare_a_out_i = '0, timer2_compare_b_enable_i = '0;
	logic timer2_compare_b_out_i = '0, timer1_compare_a_enable_i = '0, timer1_compare_a_out_i = '0;
	logic timer1_compare_b_enable_i = '0, timer1_compare_b_out_i = '0, usart1_sync_clock_out_i = '0;
	logic [7:0] port_c_direction_i = '0, port_c_output_latch_i = '0, port_c_pin_change_mask_i = '0;
	logic [7:0] c_ext_en = '0, c_ext = '0, pad_c_in_i;
	logic [7:4] port_d_direction_i = '0, port_d_output_latch_i = '0, port_d_pin_change_mask_i = '0;
	logic [7:4] d_ext_en = '0, d_ext = '0, pad_d_in_i;
	logic [7:0] pad_c_out_o, pad_c_oe_n_o, pad_c_pullup_o, pad_c_input_enable_o, pin_change_c_o;
	logic [7:4] pad_d_out_o, pad_d_oe_n_o, pad_d_pullup_o, pad_d_input_enable_o, pin_change_d_o;
	logic pin_change_24_o, jtag_tdi_o, jtag_tms_o, jtag_tck_o, two_wire_sda_in_o, two_wire_scl_in_o;
	logic timer2_osc_input_o, timer2_osc_output_active_o, timer1_capture_in_o, usart1_sync_clock_o;
	logic usart0_rx_o, timer3_count_input_o;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	pcdovr_port_override pcdovr_port_override_inst (.*);
	pcdovr_pad_model pcdovr_pad_model_inst (.clk_i, .c_out_i(pad_c_out_o), .c_oe_n_i(pad_c_oe_n_o),
		.c_pu_i(pad_c_pullup_o), .c_ext_en_i(c_ext_en), .c_ext_i(c_ext), .d_out_i(pad_d_out_o),
		.d_oe_n_i(pad_d_oe_n_o), .d_pu_i(pad_d_pullup_o), .d_ext_en_i(d_ext_en), .d_ext_i(d_ext),
		.c_pad_o(pad_c_in_i), .d_pad_o(pad_d_in_i));
	always #5 clk_i = ~clk_i;
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 500) begin
			n_fail++;
			report_and_stop();
		end
	end
	// Pad feedback needs two edges: one to drive the pad, one to sample it.
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	initial begin
		tick(6);
		chk("rst_c_oe_n", 8'hFF, pad_c_oe_n_o);
		chk("rst_d_oe_n", 4'hF, pad_d_oe_n_o);
		chk("rst_c_pullup", 8'h00, pad_c_pullup_o);
		rst_n_i = 1'b1;
		{port_c_direction_i, sleep_input_disable_i, c_ext_en, c_ext} = {8'hFF, 1'b1, 8'h2C, 8'h08};
		{jtag_port_enable_i, tap_shift_data_state_i, jtag_tdo_i} = 3'h7;
		tick(2);
		chk("c_oe_n", 8'h2C, pad_c_oe_n_o);
		chk("c_out", 8'h10, pad_c_out_o);
		chk("c_pullup", 8'h3C, pad_c_pullup_o);
		chk("c_ie", 8'h3C, pad_c_input_enable_o);
		chk("jtag_in", 3'b010, {jtag_tdi_o, jtag_tms_o, jtag_tck_o});
		chk("pc_c", 8'h18, pin_change_c_o);
		{tap_shift_data_state_i, tap_shift_instruction_state_i, jtag_tdo_i, c_ext} = {3'b010, 8'h24};
		tick(2);
		chk("c_oe_n", 8'h2C, pad_c_oe_n_o);
		chk("c_out", 8'h00, pad_c_out_o);
		chk("jtag_in", 3'b101, {jtag_tdi_o, jtag_tms_o, jtag_tck_o});
		tap_shift_instruction_state_i = 1'b0;
		tick(1);
		chk("c_oe_n", 8'h3C, pad_c_oe_n_o);
		jtag_port_enable_i = 1'b0;
		tick(1);
		chk("c_pullup", 8'h00, pad_c_pullup_o);
		chk("jtag_in", 3'b000, {jtag_tdi_o, jtag_tms_o, jtag_tck_o});
		{port_c_direction_i, port_c_output_latch_i, c_ext_en} = {8'h00, 8'h03, 8'h00};
		{two_wire_enable_i, two_wire_sda_out_i, two_wire_scl_out_i} = 3'h6;
		tick(2);
		chk("c_oe_n", 8'hFF, pad_c_oe_n_o);
		chk("c_out", 8'h02, pad_c_out_o);
		chk("c_pullup", 8'h03, pad_c_pullup_o);
		chk("tw_in", 2'b11, {two_wire_sda_in_o, two_wire_scl_in_o});
		{global_pullup_disable_i, c_ext_en, c_ext} = {1'b1, 8'h03, 8'h01};
		tick(2);
		chk("c_pullup", 8'h00, pad_c_pullup_o);
		chk("tw_in", 2'b01, {two_wire_sda_in_o, two_wire_scl_in_o});
		{two_wire_enable_i, global_pullup_disable_i, c_ext_en} = {2'b00, 8'h00};
		{port_c_direction_i, port_c_output_latch_i} = {8'h0F, 8'hFF};
		tick(1);
		chk("c_pullup", 8'hF0, pad_c_pullup_o);
		chk("c_out", 8'hFF, pad_c_out_o);
		global_pullup_disable_i = 1'b1;
		tick(1);
		chk("c_pullup", 8'h00, pad_c_pullup_o);
		{global_pullup_disable_i, port_c_direction_i, port_c_output_latch_i} = {1'b0, 8'h00, 8'hC0};
		{c_ext_en, c_ext, timer2_async_select_i} = {8'h40, 8'h40, 1'b1};
		tick(2);
		chk("c_pullup", 8'h80, pad_c_pullup_o);
		chk("c_ie", 8'h40, pad_c_input_enable_o);
		chk("osc", 2'b10, {timer2_osc_input_o, timer2_osc_output_active_o});
		{timer2_ext_clock_select_i, port_c_direction_i} = {1'b1, 8'hC0};
		tick(1);
		chk("c_pullup", 8'h00, pad_c_pullup_o);
		chk("c_oe_n", 8'hFF, pad_c_oe_n_o);
		chk("c_ie", 8'hC0, pad_c_input_enable_o);
		chk("osc_act", 1'b1, timer2_osc_output_active_o);
		{timer2_async_select_i, c_ext_en} = {1'b0, 8'h00};
		tick(2);
		chk("c_oe_n", 8'h3F, pad_c_oe_n_o);
		chk("c_ie", 8'h00, pad_c_input_enable_o);
		chk("osc", 2'b00, {timer2_osc_input_o, timer2_osc_output_active_o});
		{timer2_ext_clock_select_i, port_c_direction_i, port_c_output_latch_i} = {1'b0, 16'h0000};
		{c_ext_en, c_ext, port_c_pin_change_mask_i} = {8'hFF, 8'hA5, 8'hFF};
		{d_ext_en, d_ext, port_d_pin_change_mask_i} = {4'hF, 4'h5, 4'hF};
		{port_c_pin_change_group_enable_i, port_d_pin_change_group_enable_i} = 2'b11;
		{port_d0_pin_change_mask_i, pad_d0_in_i} = 2'b11;
		tick(2);
		chk("c_ie", 8'hFF, pad_c_input_enable_o);
		chk("pc_c", 8'hA5, pin_change_c_o);
		chk("d_ie", 4'hF, pad_d_input_enable_o);
		chk("pc_d", 4'h5, pin_change_d_o);
		chk("d0", 3'b111, {pin_change_24_o, usart0_rx_o, timer3_count_input_o});
		chk("capture", 1'b1, timer1_capture_in_o);
		{port_c_pin_change_mask_i, port_d_pin_change_group_enable_i, port_d0_pin_change_mask_i} = 10'h03C;
		tick(1);
		chk("c_ie", 8'h0F, pad_c_input_enable_o);
		chk("pc_c", 8'h05, pin_change_c_o);
		chk("pc_d", 4'h0, pin_change_d_o);
		chk("d0", 3'b000, {pin_change_24_o, usart0_rx_o, timer3_count_input_o});
		chk("capture", 1'b0, timer1_capture_in_o);
		{sleep_input_disable_i, port_d_direction_i, port_d_output_latch_i, d_ext_en} = 13'h0F20;
		{timer2_compare_a_enable_i, timer2_compare_a_out_i} = 2'b11;
		{timer2_compare_b_enable_i, timer2_compare_b_out_i} = 2'b11;
		{timer1_compare_a_enable_i, timer1_compare_a_out_i} = 2'b10;
		{timer1_compare_b_enable_i, timer1_compare_b_out_i} = 2'b11;
		tick(1);
		chk("d_out", 4'hD, pad_d_out_o);
		chk("d_oe_n", 4'h0, pad_d_oe_n_o);
		{timer2_compare_a_enable_i, timer2_compare_b_enable_i} = 2'b00;
		{timer1_compare_a_enable_i, timer1_compare_b_enable_i} = 2'b00;
		{usart1_sync_mode_i, usart1_sync_clock_out_i} = 2'b11;
		tick(1);
		chk("d_out", 4'h3, pad_d_out_o);
		{port_d_direction_i, d_ext_en, d_ext} = 12'hE11;
		tick(2);
		chk("d_oe_n", 4'h1, pad_d_oe_n_o);
		chk("usart1_clk", 1'b1, usart1_sync_clock_o);
		usart1_sync_mode_i = 1'b0;
		tick(1);
		chk("usart1_clk", 1'b0, usart1_sync_clock_o);
		{port_d_direction_i, port_d_output_latch_i} = 8'h0F;
		tick(1);
		chk("d_pullup", 4'hF, pad_d_pullup_o);
		global_pullup_disable_i = 1'b1;
		tick(2);
		chk("d_pullup", 4'h0, pad_d_pullup_o);
		report_and_stop();
	end
endmodule // tb_pcdovr_port_override
`default_nettype wire
